// >>> design/gauge_param_defs.svh
// Parameter indices, codes, float constants and timing counts of the gauge parameter bank
`ifndef GAUGE_PARAM_DEFS_SVH
`define GAUGE_PARAM_DEFS_SVH

// ****************************************
// Addressing: slot and subslot groups
// ****************************************
`define SLOT_ADJ        16'h0000
`define SUBSLOT_ADJ     16'h000A
`define SLOT_SENS       16'h0001
`define SUBSLOT_SENS    16'h0001

// ****************************************
// Parameter indices
// ****************************************
`define IDX_ZERO_CMD    16'h0370
`define IDX_ZERO_STAT   16'h0371
`define IDX_ZERO_RESP   16'h0372
`define IDX_DIA_VALUE   16'h0100
`define IDX_DIA_VALID   16'h0101
`define IDX_DIA_OVER    16'h0102
`define IDX_DIA_UNDER   16'h0103
`define IDX_DIA_WARN    16'h0140
`define IDX_DIA_ERR     16'h0141
`define IDX_AMB_VALUE   16'h0200
`define IDX_AMB_VALID   16'h0201
`define IDX_AMB_OVER    16'h0202
`define IDX_AMB_UNDER   16'h0203
`define IDX_AMB_WARN    16'h0240
`define IDX_AMB_ERR     16'h0241

// ****************************************
// Read lengths in bytes
// ****************************************
`define LEN_CMD         3'h6
`define LEN_FLOAT       3'h4
`define LEN_RESP        3'h3
`define LEN_WORD        3'h2
`define LEN_BYTE        3'h1

// ****************************************
// Command, status and response codes
// ****************************************
`define CMD_NO_OFFSET   8'h00
`define CMD_TARGET      8'h02
`define INST_A          8'h01
`define INST_B          8'h02
`define STAT_NONE       8'h00
`define STAT_OK         8'h01
`define STAT_ERR        8'h03
`define STAT_BUSY       8'hFF
`define RESP_OK         8'h00
`define RESP_FAIL       8'h01
`define RESP_NONE       8'hFE

// ****************************************
// Float32 constants in mbar, and the crossover span as a bit-pattern count
// ****************************************
`define F_ZERO_LIMIT    32'h3DCCCCCD
`define F_ZERO_DEFAULT  32'h3851B717
`define F_CROSS_LO      32'h3F800000
`define F_CROSS_HI      32'h41200000
`define F_DIA_SPAN_HI   32'h44BB8000
`define F_AMB_SPAN_LO   32'h42C80000
`define F_AMB_SPAN_HI   32'h44BB8000
`define F_MAX           32'h7F7FFFFF
`define CROSS_SPAN      44'sh0D0

// ****************************************
// Status bit positions
// ****************************************
`define BIT_WARN_ELEC   1
`define BIT_ERR_MEMB    0
`define BIT_ERR_ELEC    1

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   20
`define ADJ_TIME_NS     320
`define ADJ_CYCLES      ((`ADJ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> design/gauge_param_pkg.sv
// Types shared by the gauge parameter bank modules
package gauge_param_pkg;

  // Zero adjust sequencer states
  typedef enum logic [1:0] {ADJ_IDLE, ADJ_CONVERT, ADJ_RUN} adj_e;

  // Whole state of the bank
  typedef struct packed {
    adj_e        state;     // Sequencer state
    logic [47:0] cmd;       // Last command written
    logic [7:0]  status;    // Adjust status byte
    logic [7:0]  result;    // Response result byte
    logic [7:0]  timer;     // Adjust run counter
    logic        cmdGood;   // Command accepted for adjusting
    logic [31:0] target;    // Target in mbar
    logic [31:0] zeroRaw;   // Raw reading at last successful adjust
    logic [31:0] zeroRef;   // Reading it was made to show
    logic [31:0] pressure;  // Combined output pressure
    logic        respValid; // Answer strobe
    logic        respOk;    // Answer accepted
    logic [47:0] rdData;    // Answer data
    logic [2:0]  rdLen;     // Answer length
  } bank_s;

  // State of one range checker
  typedef struct packed {
    logic [31:0] value;
    logic        valid;
    logic        over;
    logic        under;
  } flags_s;

endpackage

// >>> design/float_mul.sv
// Float32 multiplier, truncating, zero for tiny results, saturating for huge ones
`timescale 1ns/100ps
`include "gauge_param_defs.svh"
module float_mul (
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic      [31:0] y
);
  import gauge_param_pkg::*;

  logic [47:0] prod;   // Mantissa product
  logic [9:0]  expSum; // Biased exponent sum plus normalise carry
  logic [22:0] frac;   // Normalised fraction

  // ****************************************
  // Multiply and normalise
  // ****************************************
  always_comb begin
    prod   = {24'h000000, 1'b1, a[22:0]} * {24'h000000, 1'b1, b[22:0]};
    expSum = {2'b00, a[30:23]} + {2'b00, b[30:23]} + {9'h000, prod[47]};
    frac   = prod[47] ? prod[46:24] : prod[45:23];
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || expSum < 10'h080) begin
      // Zero operand or underflow
      y = 32'h00000000;
    end else if (expSum > 10'h17D) begin
      // Overflow saturates
      y     = `F_MAX;
      y[31] = a[31] ^ b[31];
    end else begin
      y = {a[31] ^ b[31], 8'(expSum - 10'h07F), frac};
    end
  end
endmodule

// >>> design/sensor_flags.sv
// Range checker for one sensor: clamped value and valid, over and under flags
`timescale 1ns/100ps
`include "gauge_param_defs.svh"
module sensor_flags #(
  parameter logic [31:0] SPAN_LO = `F_CROSS_LO,
  parameter logic [31:0] SPAN_HI = `F_DIA_SPAN_HI
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] rawValue,
  output logic      [31:0] value,
  output logic             valid,
  output logic             over,
  output logic             under
);
  import gauge_param_pkg::*;

  flags_s s_q; // Registered flags
  flags_s s_d; // Next flags

  // ****************************************
  // Range compare, positive floats order as integers
  // ****************************************
  always_comb begin
    s_d       = s_q;
    s_d.under = rawValue[31] || (rawValue < SPAN_LO);
    s_d.over  = !rawValue[31] && (rawValue > SPAN_HI);
    s_d.valid = !s_d.under && !s_d.over;
    // Value shown only inside the span
    s_d.value = s_d.under ? SPAN_LO : (s_d.over ? SPAN_HI : rawValue);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
  assign valid = s_q.valid;
  assign over  = s_q.over;
  assign under = s_q.under;
endmodule

// >>> design/gauge_sensor_param_bank.sv
// Gauge parameter bank: zero adjust decoder and diaphragm and ambient sensor parameters
// Behaviour
// R1 - Zero adjust only below 1e-1 mbar
// R2 - No-offset adjust makes reading 5e-5 mbar
// R3 - Master sends 00, instance, four zero bytes
// R4 - Instance 1 and 2 both accepted
// R5 - Master sends 02, instance, float LSB first
// R6 - Target adjust makes reading equal target
// R7 - Target taken in current unit, converted
// R8 - Valid command write starts the adjustment
// R9 - Heat below 1, diaphragm above 10, blend
// R10 - Diaphragm value shown within 1..1500 mbar
// R11 - Valid flag 1 within accuracy, else 0
// R12 - Over-range flag 1 when over range
// R13 - Under-range flag 1 when under range
// R14 - Warning word bit 1 electronics warning
// R15 - Error word bit 0 diaphragm failure
// R16 - Ambient error bit 1 electronics failure
// R17 - Ambient value only when sensor fitted
// R18 - Diaphragm parameters only when sensor fitted
// R19 - Status 255 busy, 1 ok, 3 error
// R20 - Command read returns last written command
// R21 - Bad or high-pressure command ends in error
`timescale 1ns/100ps
`include "gauge_param_defs.svh"
module gauge_sensor_param_bank (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [15:0] reqIndex,
  input  wire logic [15:0] reqSlot,
  input  wire logic [15:0] reqSubslot,
  input  wire logic [47:0] wrData,
  output logic             respValid,
  output logic             respOk,
  output logic      [47:0] rdData,
  output logic      [2:0]  rdLen,
  input  wire logic [31:0] heatValue,
  input  wire logic [31:0] diaphragmValue,
  input  wire logic [31:0] ambientValue,
  input  wire logic [31:0] unitToMbar,
  input  wire logic        diaphragmFitted,
  input  wire logic        ambientFitted,
  input  wire logic        diaphragmElecWarn,
  input  wire logic        diaphragmMembraneFail,
  input  wire logic        ambientElecWarn,
  input  wire logic        ambientMembraneFail,
  input  wire logic        ambientElecFail,
  output logic      [31:0] pressureOut,
  output logic             adjustBusy
);
  import gauge_param_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  bank_s       s_q;      // Registered state
  bank_s       s_d;      // Next state
  logic [31:0] heat;     // Zero-corrected heat reading
  logic [31:0] mulOut;   // Target converted to mbar
  logic [31:0] diaValue; // Clamped diaphragm value
  logic        diaValid; // Diaphragm flags
  logic        diaOver;
  logic        diaUnder;
  logic [31:0] ambValue; // Clamped ambient value
  logic        ambValid; // Ambient flags
  logic        ambOver;
  logic        ambUnder;
  logic [15:0] diaWarn;  // Status words
  logic [15:0] diaErr;
  logic [15:0] ambWarn;
  logic [15:0] ambErr;
  logic        adjSel;   // Address group hits
  logic        senSel;

  // Zero correction on bit patterns, clamped at zero and max
  function automatic logic [31:0] corrHeat(input logic [31:0] raw,
                                           input logic [31:0] zRaw,
                                           input logic [31:0] zRef);
    logic [33:0] sum;
    sum      = {2'b00, raw} + {2'b00, zRef} - {2'b00, zRaw};
    corrHeat = sum[33] ? 32'h00000000 : (sum[32] ? `F_MAX : sum[31:0]);
  endfunction

  // Crossover blend, weight grows with pressure from 1 to 10 mbar
  function automatic logic [31:0] blend(input logic [31:0] ht,
                                        input logic [31:0] diaphragm_sensor);
    logic [7:0]         w;
    logic signed [33:0] delta;
    logic signed [43:0] scaled;
    w        = 8'((ht - `F_CROSS_LO) >> 17);
    delta    = $signed({2'b00, diaphragm_sensor}) - $signed({2'b00, ht});
    scaled   = delta * $signed({1'b0, w});
    scaled   = scaled / `CROSS_SPAN;
    blend    = 32'($signed({12'h000, ht}) + scaled);
  endfunction

  // Command layout check
  function automatic logic cmdLegal(input logic [47:0] c);
    logic instOk;
    // R4 both instances
    instOk   = (c[15:8] == `INST_A) || (c[15:8] == `INST_B);
    // R3 no-offset form carries zero payload
    cmdLegal = instOk && ((c[7:0] == `CMD_NO_OFFSET && c[47:16] == 32'h00000000) ||
                          c[7:0] == `CMD_TARGET);
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  // R7 target unit converted to mbar
  float_mul u_mul (
    .a (s_q.cmd[47:16]),
    .b (unitToMbar),
    .y (mulOut)
  );

  // R10 diaphragm span 1..1500 mbar
  sensor_flags #(
    .SPAN_LO (`F_CROSS_LO),
    .SPAN_HI (`F_DIA_SPAN_HI)
  ) u_diaFlags (
    .clk      (clk),
    .reset    (reset),
    .rawValue (diaphragmValue),
    .value    (diaValue),
    .valid    (diaValid),
    .over     (diaOver),
    .under    (diaUnder)
  );

  sensor_flags #(
    .SPAN_LO (`F_AMB_SPAN_LO),
    .SPAN_HI (`F_AMB_SPAN_HI)
  ) u_ambFlags (
    .clk      (clk),
    .reset    (reset),
    .rawValue (ambientValue),
    .value    (ambValue),
    .valid    (ambValid),
    .over     (ambOver),
    .under    (ambUnder)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d           = s_q;
    s_d.respValid = 1'b0;
    s_d.respOk    = 1'b0;
    heat          = corrHeat(heatValue, s_q.zeroRaw, s_q.zeroRef);
    adjSel        = (reqSlot == `SLOT_ADJ) && (reqSubslot == `SUBSLOT_ADJ);
    senSel        = (reqSlot == `SLOT_SENS) && (reqSubslot == `SUBSLOT_SENS);
    // R14 R15 R16 status words
    diaWarn                 = 16'h0000;
    diaWarn[`BIT_WARN_ELEC] = diaphragmElecWarn;
    diaErr                  = 16'h0000;
    diaErr[`BIT_ERR_MEMB]   = diaphragmMembraneFail;
    ambWarn                 = 16'h0000;
    ambWarn[`BIT_WARN_ELEC] = ambientElecWarn;
    ambErr                  = 16'h0000;
    ambErr[`BIT_ERR_MEMB]   = ambientMembraneFail;
    ambErr[`BIT_ERR_ELEC]   = ambientElecFail;

    // R9 sensor crossover
    if (!diaphragmFitted || heat < `F_CROSS_LO) begin
      s_d.pressure = heat;
    end else if (heat > `F_CROSS_HI) begin
      s_d.pressure = diaphragmValue;
    end else begin
      s_d.pressure = blend(heat, diaphragmValue);
    end

    // Parameter access, answered next cycle
    if (reqValid) begin
      s_d.respValid = 1'b1;
      s_d.rdData    = 48'h000000000000;
      s_d.rdLen     = 3'h0;
      if (reqWrite) begin
        // R8 command write starts adjust, refused while busy
        if (adjSel && reqIndex == `IDX_ZERO_CMD && s_q.state == ADJ_IDLE) begin
          s_d.respOk  = 1'b1;
          s_d.cmd     = wrData;
          s_d.state   = ADJ_CONVERT;
          s_d.status  = `STAT_BUSY;
          // R1 R21 pressure limit and layout
          s_d.cmdGood = cmdLegal(wrData) && (heat < `F_ZERO_LIMIT);
        end
      end else if (adjSel) begin
        s_d.respOk = 1'b1;
        case (reqIndex)
          // R20 last command read back
          `IDX_ZERO_CMD: begin
            s_d.rdData = s_q.cmd;
            s_d.rdLen  = `LEN_CMD;
          end
          `IDX_ZERO_STAT: begin
            s_d.rdData = {40'h0000000000, s_q.status};
            s_d.rdLen  = `LEN_BYTE;
          end
          `IDX_ZERO_RESP: begin
            s_d.rdData = {24'h000000, s_q.result, 8'h00, s_q.status};
            s_d.rdLen  = `LEN_RESP;
          end
          default: begin
            s_d.respOk = 1'b0;
          end
        endcase
      end else if (senSel) begin
        s_d.respOk = 1'b1;
        s_d.rdLen  = `LEN_BYTE;
        // R11 R12 R13 flags as whole bytes
        case (reqIndex)
          `IDX_DIA_VALUE: begin
            s_d.rdData = {16'h0000, diaValue};
            s_d.rdLen  = `LEN_FLOAT;
          end
          `IDX_DIA_VALID: s_d.rdData = {47'h0, diaValid};
          `IDX_DIA_OVER:  s_d.rdData = {47'h0, diaOver};
          `IDX_DIA_UNDER: s_d.rdData = {47'h0, diaUnder};
          `IDX_DIA_WARN: begin
            s_d.rdData = {32'h00000000, diaWarn};
            s_d.rdLen  = `LEN_WORD;
          end
          `IDX_DIA_ERR: begin
            s_d.rdData = {32'h00000000, diaErr};
            s_d.rdLen  = `LEN_WORD;
          end
          `IDX_AMB_VALUE: begin
            s_d.rdData = {16'h0000, ambValue};
            s_d.rdLen  = `LEN_FLOAT;
          end
          `IDX_AMB_VALID: s_d.rdData = {47'h0, ambValid};
          `IDX_AMB_OVER:  s_d.rdData = {47'h0, ambOver};
          `IDX_AMB_UNDER: s_d.rdData = {47'h0, ambUnder};
          `IDX_AMB_WARN: begin
            s_d.rdData = {32'h00000000, ambWarn};
            s_d.rdLen  = `LEN_WORD;
          end
          `IDX_AMB_ERR: begin
            s_d.rdData = {32'h00000000, ambErr};
            s_d.rdLen  = `LEN_WORD;
          end
          default: begin
            s_d.respOk = 1'b0;
            s_d.rdLen  = 3'h0;
          end
        endcase
        // R17 R18 absent sensors answer nothing
        if ((reqIndex[15:8] == 8'h01 && !diaphragmFitted) ||
            (reqIndex[15:8] == 8'h02 && !ambientFitted)) begin
          s_d.respOk = 1'b0;
          s_d.rdData = 48'h000000000000;
          s_d.rdLen  = 3'h0;
        end
      end
    end

    // Adjust sequencer
    case (s_q.state)
      ADJ_IDLE: begin
      end
      ADJ_CONVERT: begin
        // R7 target converted, default 5e-5 otherwise
        s_d.target = (s_q.cmd[7:0] == `CMD_TARGET) ? mulOut : `F_ZERO_DEFAULT;
        s_d.timer  = 8'(`ADJ_CYCLES);
        s_d.state  = ADJ_RUN;
      end
      ADJ_RUN: begin
        s_d.timer = s_q.timer - 8'h01;
        if (s_q.timer == 8'h01) begin
          s_d.state = ADJ_IDLE;
          // R19 R21 completion code
          if (s_q.cmdGood) begin
            // R2 R6 reading pinned to target here
            s_d.status  = `STAT_OK;
            s_d.result  = `RESP_OK;
            s_d.zeroRaw = heatValue;
            s_d.zeroRef = s_q.target;
          end else begin
            s_d.status = `STAT_ERR;
            s_d.result = `RESP_FAIL;
          end
        end
      end
      default: begin
        s_d.state = ADJ_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q        <= '0;
      s_q.state  <= ADJ_IDLE;
      s_q.status <= `STAT_NONE;
      s_q.result <= `RESP_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign respValid   = s_q.respValid;
  assign respOk      = s_q.respOk;
  assign rdData      = s_q.rdData;
  assign rdLen       = s_q.rdLen;
  assign pressureOut = s_q.pressure;
  assign adjustBusy  = (s_q.state != ADJ_IDLE);

  // ****************************************
  // Assertions
  // ****************************************
  localparam int ADJ_WAIT = 24;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic cmdWrite; // Accepted command write
  assign cmdWrite = reqValid && reqWrite && adjSel && reqIndex == `IDX_ZERO_CMD && !adjustBusy;

  property p_zeroLimit;
    cmdWrite && heat >= `F_ZERO_LIMIT |-> ##[2:ADJ_WAIT] s_q.status == `STAT_ERR;
  endproperty
  a_zeroLimit: assert property (p_zeroLimit) else $error("adjust above limit not refused"); // R1

  property p_defaultZero;
    $rose(s_q.status == `STAT_OK) && s_q.cmd[7:0] == `CMD_NO_OFFSET && $stable(heatValue)
      |-> heat == `F_ZERO_DEFAULT;
  endproperty
  a_defaultZero: assert property (p_defaultZero) else $error("reading not at default zero"); // R2

  property p_instance;
    cmdWrite && wrData == 48'h000000000200 && heat < `F_ZERO_LIMIT
      |-> ##[2:ADJ_WAIT] s_q.status == `STAT_OK;
  endproperty
  a_instance: assert property (p_instance) else $error("instance 2 not accepted"); // R4

  property p_targetZero;
    $rose(s_q.status == `STAT_OK) && s_q.cmd[7:0] == `CMD_TARGET && $stable(heatValue)
      |-> heat == s_q.target;
  endproperty
  a_targetZero: assert property (p_targetZero) else $error("reading not at target"); // R6

  property p_busy;
    cmdWrite |=> (s_q.status == `STAT_BUSY && adjustBusy) [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("status not busy while adjusting"); // R19

  property p_cmdRead;
    reqValid && !reqWrite && adjSel && reqIndex == `IDX_ZERO_CMD |=> rdData == s_q.cmd && respOk;
  endproperty
  a_cmdRead: assert property (p_cmdRead) else $error("command readback wrong"); // R20

  property p_lowBand;
    heat < `F_CROSS_LO |=> pressureOut == $past(heat);
  endproperty
  a_lowBand: assert property (p_lowBand) else $error("low band not from heat sensor"); // R9

  property p_diaErr;
    reqValid && !reqWrite && senSel && reqIndex == `IDX_DIA_ERR && diaphragmFitted
      |=> rdData[`BIT_ERR_MEMB] == $past(diaphragmMembraneFail) && rdLen == `LEN_WORD;
  endproperty
  a_diaErr: assert property (p_diaErr) else $error("diaphragm failure bit wrong"); // R15

  property p_absent;
    reqValid && senSel && reqIndex[15:8] == 8'h01 && !diaphragmFitted |=> respValid && !respOk;
  endproperty
  a_absent: assert property (p_absent) else $error("absent sensor answered"); // R18

  c_okAdjust:  cover property (s_q.state == ADJ_RUN ##1 s_q.status == `STAT_OK);
  c_errAdjust: cover property (s_q.state == ADJ_RUN ##1 s_q.status == `STAT_ERR);
  c_target:    cover property (cmdWrite && wrData[7:0] == `CMD_TARGET);
  c_blend:     cover property (heat > `F_CROSS_LO && heat < `F_CROSS_HI && diaphragmFitted);
endmodule

// >>> verification/param_master.sv
// Fieldbus master model issuing one-cycle parameter requests
`timescale 1ns/100ps
`include "gauge_param_defs.svh"
module param_master (
  input  wire logic        clk,
  input  wire logic        respValid,
  input  wire logic        respOk,
  input  wire logic [47:0] rdData,
  output logic             reqValid,
  output logic             reqWrite,
  output logic      [15:0] reqIndex,
  output logic      [15:0] reqSlot,
  output logic      [15:0] reqSubslot,
  output logic      [47:0] wrData
);
  // Idle bus at time zero
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqIndex = 16'h0000;
    reqSlot = 16'h0000;
    reqSubslot = 16'h0000;
    wrData = 48'h0;
  end

  function automatic logic [47:0] cmd(input logic [7:0] kind, input logic [7:0] inst, input logic [31:0] val);
    return {val, inst, kind};
  endfunction

  // One access; got stays low if no answer came
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [47:0] data,
                      output logic got, output logic ok, output logic [47:0] rd);
    got = 1'b0;
    ok = 1'b0;
    rd = 48'h0;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqIndex <= idx;
    reqSlot <= (idx[15:8] == 8'h03) ? `SLOT_ADJ : `SLOT_SENS;
    reqSubslot <= (idx[15:8] == 8'h03) ? `SUBSLOT_ADJ : `SUBSLOT_SENS;
    wrData <= data;
    @(posedge clk);
    reqValid <= 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge clk);
      if (respValid === 1'b1) begin
        got = 1'b1;
        ok = respOk;
        rd = rdData;
      end
    end
    // Index and data lines do not keep the last value
    reqIndex <= ~idx;
    wrData <= ~data;
  endtask
endmodule

// >>> verification/gauge_sensor_param_bank_tb.sv
// Self-checking bench for the gauge parameter bank
`timescale 1ns/100ps
`include "gauge_param_defs.svh"
module gauge_sensor_param_bank_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        reqValid, reqWrite, respValid, respOk, adjustBusy, got, ok;
  logic [15:0] reqIndex, reqSlot, reqSubslot;
  logic [47:0] wrData, rdData, rd;
  logic [2:0]  rdLen;
  logic [31:0] heat = 32'h3A83126F;
  logic [31:0] dia = 32'h42C80000;
  logic [31:0] amb = 32'h447A0000;
  logic [31:0] unit = 32'h3F800000;
  logic [31:0] pressureOut;
  logic [4:0]  fault = 5'h00;
  logic        diaFit = 1'b1;
  logic        ambFit = 1'b1;
  int          errCount = 0;
  int          nCompared = 0;

  always #10 clk = ~clk;

  // ****************************************
  // Instances
  // ****************************************
  gauge_sensor_param_bank dut_u (.clk(clk), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqIndex(reqIndex), .reqSlot(reqSlot), .reqSubslot(reqSubslot), .wrData(wrData), .respValid(respValid),
    .respOk(respOk), .rdData(rdData), .rdLen(rdLen), .heatValue(heat), .diaphragmValue(dia),
    .ambientValue(amb), .unitToMbar(unit), .diaphragmFitted(diaFit), .ambientFitted(ambFit),
    .diaphragmElecWarn(fault[0]), .diaphragmMembraneFail(fault[1]), .ambientElecWarn(fault[2]),
    .ambientMembraneFail(fault[3]), .ambientElecFail(fault[4]), .pressureOut(pressureOut),
    .adjustBusy(adjustBusy));
  param_master master_u (.clk(clk), .respValid(respValid), .respOk(respOk), .rdData(rdData),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqIndex(reqIndex), .reqSlot(reqSlot),
    .reqSubslot(reqSubslot), .wrData(wrData));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrapUp;
    if (errCount == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare two values
  task automatic check(input logic [47:0] g, input logic [47:0] e);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Access and judge acceptance
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [47:0] data, input logic expOk);
    master_u.xfer(wr, idx, data, got, ok, rd);
    if (got !== 1'b1) begin
      errCount++;
      wrapUp();
    end
    check({47'h0, ok}, {47'h0, expOk});
  endtask

  // Read and compare data
  task automatic rdChk(input logic [15:0] idx, input logic [47:0] e);
    acc(1'b0, idx, 48'h0, 1'b1);
    check(rd, e);
  endtask

  // Bounded wait for the adjust to end
  task automatic waitIdle;
    for (int n = 0; adjustBusy !== 1'b0; n++) begin
      @(posedge clk);
      if (n > 40) begin
        errCount++;
        wrapUp();
      end
    end
    repeat (3) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic blendEnds;
    heat <= 32'h43000000;
    repeat (3) @(posedge clk);
    check(pressureOut, dia);
    heat <= 32'h3A83126F;
    repeat (3) @(posedge clk);
    check(pressureOut, heat);
  endtask

  // Over span, faults, then under span
  task automatic flagsRead;
    dia <= 32'h45000000;
    fault <= 5'h1F;
    repeat (2) @(posedge clk);
    rdChk(`IDX_DIA_VALUE, 48'h44BB8000);
    check(rdLen, `LEN_FLOAT);
    rdChk(`IDX_DIA_VALID, 48'h0);
    check(rdLen, `LEN_BYTE);
    rdChk(`IDX_DIA_OVER, 48'h1);
    rdChk(`IDX_DIA_UNDER, 48'h0);
    rdChk(`IDX_DIA_WARN, 48'h2);
    check(rdLen, `LEN_WORD);
    rdChk(`IDX_DIA_ERR, 48'h1);
    rdChk(`IDX_AMB_WARN, 48'h2);
    rdChk(`IDX_AMB_ERR, 48'h3);
    rdChk(`IDX_AMB_VALUE, 48'h447A0000);
    rdChk(`IDX_AMB_VALID, 48'h1);
    dia <= 32'h3F000000;
    amb <= 32'h42000000;
    fault <= 5'h00;
    repeat (2) @(posedge clk);
    rdChk(`IDX_DIA_UNDER, 48'h1);
    rdChk(`IDX_DIA_ERR, 48'h0);
    rdChk(`IDX_AMB_ERR, 48'h0);
    rdChk(`IDX_AMB_UNDER, 48'h1);
    rdChk(`IDX_AMB_OVER, 48'h0);
    rdChk(`IDX_AMB_VALID, 48'h0);
  endtask

  // Absent sensors and read-only places refuse
  task automatic absent;
    ambFit <= 1'b0;
    diaFit <= 1'b0;
    repeat (2) @(posedge clk);
    acc(1'b0, `IDX_AMB_VALUE, 48'h0, 1'b0);
    check(rd, 48'h0);
    check(rdLen, 48'h0);
    acc(1'b0, `IDX_DIA_VALID, 48'h0, 1'b0);
    acc(1'b1, `IDX_DIA_VALUE, 48'h5, 1'b0);
    ambFit <= 1'b1;
    diaFit <= 1'b1;
  endtask

  // Plain zero adjust with busy refusal
  task automatic zeroPlain;
    rdChk(`IDX_ZERO_RESP, 48'hFE0000);
    acc(1'b1, `IDX_ZERO_CMD, master_u.cmd(8'h00, 8'h02, 32'h0), 1'b1);
    check(adjustBusy, 48'h1);
    rdChk(`IDX_ZERO_STAT, 48'hFF);
    acc(1'b1, `IDX_ZERO_CMD, master_u.cmd(8'h00, 8'h01, 32'h0), 1'b0);
    waitIdle();
    check(adjustBusy, 48'h0);
    rdChk(`IDX_ZERO_STAT, 48'h01);
    rdChk(`IDX_ZERO_CMD, 48'h0200);
    check(rdLen, `LEN_CMD);
    rdChk(`IDX_ZERO_RESP, 48'h01);
    check(rdLen, `LEN_RESP);
    check(pressureOut, `F_ZERO_DEFAULT);
  endtask

  // Target adjust in a unit of 2 mbar
  task automatic zeroTarget;
    unit <= 32'h40000000;
    acc(1'b1, `IDX_ZERO_CMD, master_u.cmd(8'h02, 8'h02, 32'h3B3E0DED), 1'b1);
    waitIdle();
    rdChk(`IDX_ZERO_STAT, 48'h01);
    check(pressureOut, 48'h3BBE0DED);
  endtask

  // High pressure, bad instance, bad kind
  task automatic zeroBad;
    heat <= 32'h3F000000;
    acc(1'b1, `IDX_ZERO_CMD, master_u.cmd(8'h00, 8'h01, 32'h0), 1'b1);
    waitIdle();
    rdChk(`IDX_ZERO_RESP, 48'h010003);
    heat <= 32'h3A83126F;
    acc(1'b1, `IDX_ZERO_CMD, master_u.cmd(8'h00, 8'h03, 32'h0), 1'b1);
    waitIdle();
    rdChk(`IDX_ZERO_STAT, 48'h03);
    acc(1'b1, `IDX_ZERO_CMD, master_u.cmd(8'h01, 8'h01, 32'h0), 1'b1);
    waitIdle();
    rdChk(`IDX_ZERO_STAT, 48'h03);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    blendEnds();
    flagsRead();
    absent();
    zeroPlain();
    zeroTarget();
    zeroBad();
    wrapUp();
  end
endmodule
